// *** trwc_pkg.sv ***
// constants, types and register map of the tape read/write control register bank
package trwc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_SENSE = 8'h47;
  localparam logic [7:0] IDX_TRACK_MASK = 8'h48;
  localparam logic [7:0] IDX_DIAG = 8'h49;
  localparam logic [7:0] IDX_WCTL = 8'h4A;
  localparam logic [7:0] IDX_RCTL = 8'h4B;
  localparam logic [7:0] IDX_MODE = 8'h4C;
  localparam logic [7:0] IDX_SPEED = 8'h50;
  localparam logic [7:0] IDX_STATUS = 8'h51;
  localparam logic [7:0] REG_RESET = 8'h00;
  // sense register bits
  localparam int SN_TRAP_MASK = 4;
  localparam int SN_VEL_OK = 3;
  localparam int SN_VEL_CHG = 2;
  localparam int SN_GATE = 1;
  localparam int SN_STOP = 0;
  // diagnostic control bits
  localparam int DG_DIAG_WRITE = 7;
  localparam int DG_DIAG_READ = 6;
  localparam int DG_PRE_INH = 5;
  localparam int DG_POST_INH = 4;
  localparam int DG_INVALID = 3;
  localparam int DG_ALL_MASK = 2;
  localparam int DG_MASK_EN = 1;
  localparam int DG_PARITY_MASK = 0;
  // write control bits
  localparam int WC_TAPE_MARK = 7;
  localparam int WC_ID_BURST = 6;
  localparam int WC_END_HOLD = 5;
  localparam int WC_ALL_ONES = 4;
  localparam int WC_WRITE_GO = 3;
  localparam int WC_BUF_FULL = 1;
  localparam int WC_BYTE_CYC = 0;
  localparam logic [7:0] WC_STORED = 8'hF8;
  // read control bits
  localparam int RC_READ_GO = 7;
  localparam int RC_STANDBY = 6;
  localparam int RC_VFO_START = 5;
  localparam int RC_XFER_INH = 4;
  localparam int RC_CORR_INH = 3;
  localparam int RC_PHASE_INJ = 1;
  // mode register bits
  localparam int MD_MACHINE_CYCLE = 7;
  localparam int MD_WRITE_STATUS = 5;
  localparam int MD_D800 = 4;
  localparam int MD_D6250 = 3;
  localparam int MD_D1600 = 2;
  localparam int MD_CBR = 0;
  // timing: tach tick is base unit times speed factor
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_BASE_NS = 208;
  localparam int TICK_BASE_CYC = (TICK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_BITS = 12;
  localparam logic [11:0] PERIOD_FULL = 12'hFFF;
  localparam logic [11:0] VEL_LO_TICKS = 12'h0AA;
  localparam logic [11:0] VEL_HI_TICKS = 12'h104;
  localparam logic [3:0] CELLS_6250 = 4'h8;
  localparam logic [3:0] CELLS_1600 = 4'h4;
  localparam logic [3:0] CELLS_800 = 4'h2;
  localparam logic [3:0] FMT_HOLD = 4'hD;
  localparam logic [3:0] FMT_END = 4'hF;
  localparam logic [3:0] INVALID_NIBBLE = 4'hF;

  typedef enum logic [3:0] {
    VFO_DISCHARGE = 4'b0001,
    VFO_WCLK = 4'b0010,
    VFO_RESYNC = 4'b0100,
    VFO_DATA = 4'b1000
  } trwc_vfo_t;

  typedef enum logic [2:0] {
    PAT_DATA = 3'h0,
    PAT_ONES_9042 = 3'h1,
    PAT_ONES_3200 = 3'h2,
    PAT_ONES_800 = 3'h3,
    PAT_BURST_1000 = 3'h4,
    PAT_TAPE_MARK = 3'h5
  } trwc_pat_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } trwc_apb_t;

  typedef struct packed {
    logic ftp_s1;
    logic ftp_s2;
    logic ftp_prev;
    logic [3:0] presc;
    logic [11:0] period;
    logic [1:0] speed;
    logic trap_mask;
    logic vel_ok;
    logic vel_chg;
    logic gate;
    logic stop;
    logic trap;
    logic [7:0] track_mask;
    logic [7:0] diag;
    logic [7:0] wctl;
    logic [7:0] rctl;
    logic [7:0] mode;
    logic byte_cyc;
    logic [3:0] bcnt;
    logic [3:0] fcount;
    logic phase_ok;
    logic slip;
    logic noise;
    trwc_vfo_t vfo;
    logic [8:0] prev_wdata;
    logic [8:0] wdata;
    logic [8:0] pherr;
    trwc_pat_t pattern;
    logic tm_seq;
    logic id_fmt;
    logic fwd_check;
    logic xfer_req;
    trwc_apb_t apb;
  } trwc_state_t;
endpackage

// *** trwc_regs.sv ***
// tape read/write control registers: tach monitor, write masking, write and read control
`timescale 1ns/10ps

module trwc_regs
  import trwc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hardware_clear,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // tape unit tach
  input wire logic i_fine_tach_pulse,
  output logic o_tach_stop_trap,
  // write path
  input wire logic i_bit_cell,
  input wire logic i_format_step,
  input wire logic [8:0] i_write_data,
  input wire logic i_group_excluded,
  input wire logic i_in_preamble,
  input wire logic i_in_postamble,
  output logic [8:0] o_write_data,
  output logic [8:0] o_phase_error,
  output trwc_pat_t o_pattern,
  output logic o_tape_mark_seq,
  output logic o_id_burst_fmt,
  output logic o_write_go,
  output logic [3:0] o_format_count,
  // read path
  input wire logic i_buffer_full,
  input wire logic i_transfer_cond,
  input wire logic i_block_detect,
  input wire logic i_end_postamble,
  input wire logic i_slip_event,
  input wire logic i_noise_event,
  input wire logic i_time_sense,
  input wire logic i_peak_pulse,
  output logic o_forward_check,
  output logic o_transfer_request,
  output logic o_read_go,
  output logic o_correction_inhibit,
  output trwc_vfo_t o_vfo_state
);

  trwc_state_t s;
  trwc_state_t next_s;

  function automatic logic [3:0] speed_factor(input logic [1:0] code);
    case (code)
      2'b11: speed_factor = 4'h1;
      2'b10: speed_factor = 4'h2;
      2'b01: speed_factor = 4'h3;
      default: speed_factor = 4'h4;
    endcase
  endfunction

  function automatic logic [3:0] cells_per_byte(input logic [7:0] mode);
    if (mode[MD_D6250]) begin
      cells_per_byte = CELLS_6250;
    end else if (mode[MD_D1600]) begin
      cells_per_byte = CELLS_1600;
    end else begin
      cells_per_byte = CELLS_800;
    end
  endfunction

  function automatic logic [3:0] diag_group(input logic [3:0] g, input logic inv,
                                            input logic excl);
    if (!excl && g[3:2] == 2'b11) begin
      diag_group = inv ? INVALID_NIBBLE : 4'h0;
    end else begin
      diag_group = g;
    end
  endfunction

  logic [7:0] idx;
  logic access;
  logic wr;
  logic mc;
  logic d6250;
  logic d1600;
  logic d800;
  logic ftp_edge;
  logic tick;
  logic [3:0] tick_len;
  logic in_range;
  logic [8:0] mvec;
  logic [8:0] d;
  logic [7:0] rd;
  logic hit;
  logic vc_set;

  assign idx = i_paddr[9:2];
  assign access = i_psel && i_penable;
  assign wr = access && s.apb.pready && i_pwrite;
  assign mc = s.mode[MD_MACHINE_CYCLE];
  assign d6250 = s.mode[MD_D6250];
  assign d1600 = s.mode[MD_D1600];
  assign d800 = s.mode[MD_D800];
  assign ftp_edge = s.ftp_s2 && !s.ftp_prev;
  assign tick_len = 4'(TICK_BASE_CYC) * speed_factor(s.speed);
  assign tick = (s.presc == tick_len - 4'h1);
  assign in_range = (s.period >= VEL_LO_TICKS) && (s.period <= VEL_HI_TICKS);
  assign mvec = {s.diag[DG_PARITY_MASK], s.track_mask};

  always_comb begin
    next_s = s;
    rd = 8'h00;
    hit = 1'b1;
    vc_set = 1'b0;
    d = i_write_data;

    // tach pulse crossing; only the second stage is examined
    next_s.ftp_s1 = i_fine_tach_pulse;
    next_s.ftp_s2 = s.ftp_s1;
    next_s.ftp_prev = s.ftp_s2;

    // fine tach period measurement
    next_s.presc = tick ? 4'h0 : s.presc + 4'h1;
    if (ftp_edge) begin
      next_s.period = '0;
      next_s.vel_ok = in_range;
      if (!in_range && s.mode[MD_WRITE_STATUS]) begin
        next_s.vel_chg = 1'b1;
        vc_set = 1'b1;
      end
    end else if (tick && s.period != PERIOD_FULL) begin
      next_s.period = s.period + 12'h001;
      if (s.period + 12'h001 == PERIOD_FULL) begin
        next_s.vel_ok = 1'b0;
        if (!s.gate) begin
          next_s.stop = 1'b1;
        end
        if (s.mode[MD_WRITE_STATUS]) begin
          next_s.vel_chg = 1'b1;
          vc_set = 1'b1;
        end
      end
    end

    // byte cycle: counts bit cells after each clearing write
    if (!s.byte_cyc && i_bit_cell) begin
      if (s.bcnt == cells_per_byte(s.mode) - 4'h1) begin
        next_s.byte_cyc = 1'b1;
        next_s.bcnt = 4'h0;
      end else begin
        next_s.bcnt = s.bcnt + 4'h1;
      end
    end

    // format counter driven by write go
    if (!s.wctl[WC_WRITE_GO]) begin
      next_s.fcount = 4'h0;
    end else if (i_format_step) begin
      if (!(s.fcount == FMT_HOLD && s.wctl[WC_END_HOLD])) begin
        next_s.fcount = s.fcount + 4'h1;
      end
      if (s.fcount + 4'h1 == FMT_END && !(s.fcount == FMT_HOLD && s.wctl[WC_END_HOLD])) begin
        next_s.wctl[WC_WRITE_GO] = 1'b0;
      end
    end

    // phase lock and read checks, all held off without standby
    if (!s.rctl[RC_STANDBY]) begin
      next_s.phase_ok = 1'b0;
      next_s.slip = 1'b0;
      next_s.noise = 1'b0;
    end else begin
      if (i_block_detect) begin
        next_s.phase_ok = 1'b1;
      end else if (i_end_postamble && !d800) begin
        next_s.phase_ok = 1'b0;
      end
      if (i_slip_event) begin
        next_s.slip = 1'b1;
      end
      if (i_noise_event) begin
        next_s.noise = 1'b1;
      end
    end

    // vfo sequencing
    case (s.vfo)
      VFO_DISCHARGE: begin
        if (s.rctl[RC_VFO_START]) begin
          next_s.vfo = VFO_WCLK;
        end
      end
      VFO_WCLK: begin
        if (i_time_sense && s.rctl[RC_READ_GO]) begin
          next_s.vfo = VFO_RESYNC;
        end
      end
      VFO_RESYNC: begin
        if (i_peak_pulse) begin
          next_s.vfo = VFO_DATA;
        end
      end
      default: begin
        next_s.vfo = VFO_DATA;
      end
    endcase
    if (!s.rctl[RC_VFO_START]) begin
      next_s.vfo = VFO_DISCHARGE;
    end

    // write data shaping; the raw byte is kept to spot repeated ones
    next_s.prev_wdata = i_write_data;
    if (s.diag[DG_DIAG_WRITE]) begin
      if (d6250) begin
        d[7:4] = diag_group(d[7:4], s.diag[DG_INVALID], i_group_excluded);
        d[3:0] = diag_group(d[3:0], s.diag[DG_INVALID], i_group_excluded);
      end else begin
        d = d & ~s.prev_wdata;
      end
    end
    if (s.diag[DG_MASK_EN] && !s.rctl[RC_PHASE_INJ]) begin
      d = d & ~mvec;
    end
    if ((d6250 || d1600) && ((s.diag[DG_PRE_INH] && i_in_preamble) ||
                             (s.diag[DG_POST_INH] && i_in_postamble))) begin
      d = 9'h000;
    end
    if (s.diag[DG_ALL_MASK] || !mc) begin
      d = 9'h000;
    end
    next_s.wdata = d;
    next_s.pherr = (s.diag[DG_MASK_EN] && s.rctl[RC_PHASE_INJ]) ? mvec : 9'h000;

    // write pattern selection
    if (s.wctl[WC_ALL_ONES]) begin
      if (s.wctl[WC_ID_BURST] && d6250) begin
        next_s.pattern = PAT_BURST_1000;
      end else if (d6250) begin
        next_s.pattern = PAT_ONES_9042;
      end else if (d1600) begin
        next_s.pattern = PAT_ONES_3200;
      end else begin
        next_s.pattern = PAT_ONES_800;
      end
    end else if (s.wctl[WC_TAPE_MARK]) begin
      next_s.pattern = PAT_TAPE_MARK;
    end else begin
      next_s.pattern = PAT_DATA;
    end
    next_s.tm_seq = s.wctl[WC_TAPE_MARK];
    next_s.id_fmt = s.wctl[WC_ID_BURST] && (d6250 || d1600);
    next_s.fwd_check = s.diag[DG_DIAG_READ] && (d6250 || d800);
    next_s.xfer_req = i_transfer_cond && !s.rctl[RC_XFER_INH] && mc;
    next_s.trap = s.stop && s.trap_mask;

    // apb: one wait cycle, read data captured while pready is low
    next_s.apb.pready = access && !s.apb.pready;
    if (idx == IDX_SENSE) begin
      rd = {3'h0, s.trap_mask, s.vel_ok, s.vel_chg, s.gate, s.stop};
    end else if (idx == IDX_TRACK_MASK) begin
      rd = s.track_mask;
    end else if (idx == IDX_DIAG) begin
      rd = s.diag;
    end else if (idx == IDX_WCTL) begin
      rd = s.wctl & WC_STORED;
      rd[WC_BUF_FULL] = i_buffer_full && !s.mode[MD_CBR];
      rd[WC_BYTE_CYC] = s.byte_cyc;
    end else if (idx == IDX_RCTL) begin
      rd = s.rctl;
    end else if (idx == IDX_MODE) begin
      rd = s.mode;
    end else if (idx == IDX_SPEED) begin
      rd = {6'h00, s.speed};
    end else if (idx == IDX_STATUS) begin
      rd = {s.fcount, 1'b0, s.phase_ok, s.slip, s.noise};
    end else begin
      hit = 1'b0;
    end
    if (access && !s.apb.pready) begin
      next_s.apb.prdata = (i_pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rd};
      next_s.apb.pslverr = !hit || (i_paddr[1:0] != 2'b00);
    end else begin
      next_s.apb.pslverr = 1'b0;
    end

    // register writes; hardware sets above win over write-1 clears here
    if (wr && !s.apb.pslverr) begin
      if (idx == IDX_SENSE) begin
        if (mc) begin
          next_s.trap_mask = i_pwdata[SN_TRAP_MASK];
          next_s.gate = i_pwdata[SN_GATE];
        end
        if (i_pwdata[SN_VEL_CHG] && !vc_set) begin
          next_s.vel_chg = 1'b0;
        end
      end else if (idx == IDX_TRACK_MASK) begin
        next_s.track_mask = i_pwdata[7:0];
      end else if (idx == IDX_DIAG) begin
        next_s.diag = i_pwdata[7:0];
      end else if (idx == IDX_WCTL && mc) begin
        next_s.wctl = i_pwdata[7:0] & WC_STORED;
        if (i_pwdata[WC_BYTE_CYC] && !(next_s.byte_cyc && !s.byte_cyc)) begin
          next_s.byte_cyc = 1'b0;
          next_s.bcnt = 4'h0;
        end
      end else if (idx == IDX_RCTL && mc) begin
        next_s.rctl = i_pwdata[7:0];
      end else if (idx == IDX_MODE) begin
        next_s.mode = i_pwdata[7:0];
      end else if (idx == IDX_SPEED) begin
        next_s.speed = i_pwdata[1:0];
      end
    end

    // machine cycle off drops the tach monitor and the write start
    if (!mc) begin
      next_s.trap_mask = 1'b0;
      next_s.vel_ok = 1'b0;
      next_s.vel_chg = 1'b0;
      next_s.gate = 1'b0;
      next_s.stop = 1'b0;
      next_s.trap = 1'b0;
      next_s.period = '0;
      next_s.wctl[WC_WRITE_GO] = 1'b0;
    end

    if (i_hardware_clear) begin
      next_s.track_mask = REG_RESET;
      next_s.diag = REG_RESET;
      next_s.wctl = REG_RESET;
      next_s.rctl = REG_RESET;
      next_s.mode = REG_RESET;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.vfo <= VFO_DISCHARGE;
      s.pattern <= PAT_DATA;
    end else begin
      s <= next_s;
    end
  end

  assign o_pready = s.apb.pready;
  assign o_pslverr = s.apb.pslverr;
  assign o_prdata = s.apb.prdata;
  assign o_tach_stop_trap = s.trap;
  assign o_write_data = s.wdata;
  assign o_phase_error = s.pherr;
  assign o_pattern = s.pattern;
  assign o_tape_mark_seq = s.tm_seq;
  assign o_id_burst_fmt = s.id_fmt;
  assign o_write_go = s.wctl[WC_WRITE_GO];
  assign o_format_count = s.fcount;
  assign o_forward_check = s.fwd_check;
  assign o_transfer_request = s.xfer_req;
  assign o_read_go = s.rctl[RC_READ_GO];
  assign o_correction_inhibit = s.rctl[RC_CORR_INH];
  assign o_vfo_state = s.vfo;

endmodule

// *** trwc_tach_model.sv ***
// behavioural tape unit that supplies fine tach pulses at a set spacing
`timescale 1ns/10ps
module trwc_tach_model (
  // clock and pulse spacing in clock cycles, zero stops the tape
  input wire logic i_clk,
  input wire logic [15:0] i_period,
  // tach line
  output logic o_fine_tach_pulse
);
  int cnt = 0;
  initial o_fine_tach_pulse = 1'b0;
  // a standing tape gives no pulses, so the line rests low between runs
  always @(posedge i_clk) begin
    cnt <= (i_period == 16'h0 || cnt + 1 >= i_period) ? 0 : cnt + 1;
    o_fine_tach_pulse <= i_period != 16'h0 && cnt < 4;
  end
endmodule

// *** trwc_checker.sv ***
// port-level assertions for the tape read/write control registers
`timescale 1ns/10ps
module trwc_checker
  import trwc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  // write and read control
  input wire logic i_format_step,
  input wire logic o_write_go,
  input wire logic [3:0] o_format_count,
  input wire logic i_time_sense,
  input wire logic i_peak_pulse,
  input wire trwc_vfo_t o_vfo_state
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  apb_one_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access not answered after one wait state");
  apb_err_pair_a: assert property (o_pslverr |-> o_pready)
    else $error("error response without ready");
  apb_rdata_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  fmt_end_a: assert property (o_format_count == FMT_END |-> !o_write_go)
    else $error("write go still set at format count 15");
  fmt_advance_a: assert property (o_write_go && i_format_step && o_format_count < FMT_HOLD
    |=> o_format_count == $past(o_format_count) + 4'h1 || !o_write_go)
    else $error("format counter did not advance on a step");
  fmt_idle_a: assert property (!o_write_go ##1 !o_write_go |-> o_format_count == 4'h0)
    else $error("format counter not cleared while idle");
  vfo_onehot_a: assert property ($onehot(o_vfo_state))
    else $error("vfo state not one-hot");
  vfo_resync_a: assert property (o_vfo_state == VFO_RESYNC && i_peak_pulse
    |=> o_vfo_state != VFO_RESYNC)
    else $error("vfo resync longer than one peak");
  vfo_sense_a: assert property (o_vfo_state == VFO_WCLK && !i_time_sense
    |=> o_vfo_state != VFO_RESYNC && o_vfo_state != VFO_DATA)
    else $error("vfo left write clock without time sense");

  cover property (o_format_count == FMT_HOLD && o_write_go);
  cover property (o_vfo_state == VFO_DATA);
  cover property (o_pslverr);
endmodule

// *** tape_rw_control_registers_tb.sv ***
// self-checking bench for the tape read/write control registers
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module tape_rw_control_registers_tb;
  import trwc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bfull = 1'b0, xcond = 1'b0, pre = 1'b0, err, fwd, cinh;
  // pulse lines: 0 cell, 1 step, 2 sense, 3 peak, 4 block, 5 post end, 6 clear
  logic [6:0] pl = 7'h00;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [8:0] wdata = 9'h000, wdo, phase_error;
  logic [15:0] per = 16'h0;
  logic fine_tach_pulse, pready, pslverr, trap, wgo, tms, idb, xreq, rgo;
  logic [3:0] fcnt;
  logic [7:0] rd;
  trwc_pat_t pat;
  trwc_vfo_t vfo;
  int checks = 0, mismatches = 0;
  logic [7:0] dens [3] = '{8'h08, 8'h04, 8'h10};
  logic [3:0] cells [3] = '{CELLS_6250, CELLS_1600, CELLS_800};
  trwc_pat_t ones [3] = '{PAT_ONES_9042, PAT_ONES_3200, PAT_ONES_800};

  always #50 clk = ~clk;

  trwc_tach_model tach_u (.i_clk(clk), .i_period(per), .o_fine_tach_pulse(fine_tach_pulse));

  trwc_regs dut_u (
    .i_clk(clk), .i_rst(rst), .i_hardware_clear(pl[6]),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_fine_tach_pulse(fine_tach_pulse), .o_tach_stop_trap(trap),
    .i_bit_cell(pl[0]), .i_format_step(pl[1]), .i_write_data(wdata),
    .i_group_excluded(1'b0), .i_in_preamble(pre), .i_in_postamble(1'b0),
    .o_write_data(wdo), .o_phase_error(phase_error), .o_pattern(pat), .o_tape_mark_seq(tms),
    .o_id_burst_fmt(idb), .o_write_go(wgo), .o_format_count(fcnt),
    .i_buffer_full(bfull), .i_transfer_cond(xcond), .i_block_detect(pl[4]),
    .i_end_postamble(pl[5]), .i_slip_event(pl[4]), .i_noise_event(1'b0),
    .i_time_sense(pl[2]), .i_peak_pulse(pl[3]), .o_forward_check(fwd),
    .o_transfer_request(xreq), .o_read_go(rgo), .o_correction_inhibit(cinh),
    .o_vfo_state(vfo)
  );

  // one transfer; returns at the edge where ready was taken, request released
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHK(pready, 1'b1)
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge clk);
      pl[s] <= 1'b1;
      @(posedge clk);
      pl[s] <= 1'b0;
    end
  endtask

  task automatic chk_clear();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, IDX_TRACK_MASK + 8'(i), 8'h00);
      `CHK(rd, REG_RESET)
    end
  endtask

  task automatic t_reset();
    chk_clear();
    apb(1'b0, 8'h4E, 8'h00);
    `CHK(err, 1'b1)
    apb(1'b1, IDX_WCTL, 8'h18);
    apb(1'b0, IDX_WCTL, 8'h00);
    `CHK(rd, 8'h00)
  endtask

  task automatic t_tach();
    apb(1'b1, IDX_MODE, 8'h88);
    apb(1'b1, IDX_SPEED, 8'h03);
    per <= 16'((VEL_LO_TICKS + VEL_HI_TICKS) / 2 * TICK_BASE_CYC);
    repeat (4000) @(posedge clk);
    // write status only once the tape runs, so the start-up gap is not a change
    apb(1'b1, IDX_MODE, 8'hA8);
    apb(1'b1, IDX_SENSE, 8'h04);
    repeat (2000) @(posedge clk);
    apb(1'b0, IDX_SENSE, 8'h00);
    `CHK(rd & 8'h1F, 8'h08)
    per <= 16'(VEL_HI_TICKS * 2 * TICK_BASE_CYC);
    repeat (8000) @(posedge clk);
    apb(1'b0, IDX_SENSE, 8'h00);
    `CHK(rd & 8'h1F, 8'h04)
    per <= 16'((VEL_LO_TICKS + VEL_HI_TICKS) / 2 * TICK_BASE_CYC);
    repeat (4000) @(posedge clk);
    apb(1'b1, IDX_SENSE, 8'h06);
    per <= 16'h0;
    repeat (13000) @(posedge clk);
    apb(1'b0, IDX_SENSE, 8'h00);
    `CHK(rd & 8'h1F, 8'h06)
    apb(1'b1, IDX_SENSE, 8'h00);
    // the counter sits at full count, so a fresh run and stop is needed to overflow again
    per <= 16'((VEL_LO_TICKS + VEL_HI_TICKS) / 2 * TICK_BASE_CYC);
    repeat (2000) @(posedge clk);
    per <= 16'h0;
    repeat (13000) @(posedge clk);
    apb(1'b0, IDX_SENSE, 8'h00);
    `CHK(rd[0], 1'b1)
    `CHK(trap, 1'b0)
    apb(1'b1, IDX_SENSE, 8'h10);
    tick(2);
    `CHK(trap, 1'b1)
    apb(1'b1, IDX_MODE, 8'h00);
    apb(1'b0, IDX_SENSE, 8'h00);
    `CHK(rd & 8'h1F, 8'h00)
    `CHK(trap, 1'b0)
  endtask

  task automatic t_hardware_clear();
    apb(1'b1, IDX_MODE, 8'h88);
    apb(1'b1, IDX_TRACK_MASK, 8'hA5);
    apb(1'b1, IDX_DIAG, 8'h5A);
    apb(1'b1, IDX_WCTL, 8'hE0);
    apb(1'b1, IDX_RCTL, 8'hC8);
    apb(1'b0, IDX_TRACK_MASK, 8'h00);
    `CHK(rd, 8'hA5)
    pulse(6, 1);
    chk_clear();
    apb(1'b0, IDX_MODE, 8'h00);
    `CHK(rd, 8'h00)
  endtask

  task automatic t_mask();
    apb(1'b1, IDX_MODE, 8'h88);
    wdata <= 9'h1FF;
    apb(1'b1, IDX_TRACK_MASK, 8'h3C);
    tick(1);
    `CHK(wdo, 9'h1FF)
    apb(1'b1, IDX_DIAG, 8'h02);
    tick(1);
    `CHK(wdo, 9'h1C3)
    apb(1'b1, IDX_DIAG, 8'h03);
    tick(1);
    `CHK(wdo, 9'h0C3)
    apb(1'b1, IDX_DIAG, 8'h04);
    tick(1);
    `CHK(wdo, 9'h000)
    apb(1'b1, IDX_DIAG, 8'h02);
    apb(1'b1, IDX_RCTL, 8'h02);
    tick(1);
    `CHK(phase_error, 9'h03C)
    apb(1'b1, IDX_DIAG, 8'h80);
    tick(1);
    `CHK(wdo, 9'h100)
    apb(1'b1, IDX_DIAG, 8'h88);
    tick(1);
    `CHK(wdo, {1'b1, INVALID_NIBBLE, INVALID_NIBBLE})
    apb(1'b1, IDX_MODE, 8'h84);
    tick(1);
    `CHK(wdo, 9'h000)
    apb(1'b1, IDX_DIAG, 8'h60);
    pre <= 1'b1;
    tick(1);
    `CHK(wdo, 9'h000)
    `CHK(fwd, 1'b0)
    apb(1'b1, IDX_MODE, 8'h90);
    tick(1);
    `CHK(wdo, 9'h1FF)
    `CHK(fwd, 1'b1)
    @(posedge clk);
    pre <= 1'b0;
  endtask

  task automatic t_pat();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_MODE, 8'h80 | dens[i]);
      apb(1'b1, IDX_WCTL, 8'h18);
      tick(1);
      `CHK(pat, ones[i])
      apb(1'b1, IDX_WCTL, 8'h58);
      tick(1);
      `CHK(idb, 1'(i < 2))
      if (i == 0) `CHK(pat, PAT_BURST_1000)
      apb(1'b1, IDX_WCTL, 8'h88);
      tick(1);
      `CHK(tms, 1'b1)
    end
  endtask

  task automatic t_fmt();
    apb(1'b1, IDX_MODE, 8'h88);
    apb(1'b1, IDX_WCTL, 8'h00);
    apb(1'b1, IDX_WCTL, 8'h38);
    pulse(1, 20);
    tick(1);
    `CHK(fcnt, FMT_HOLD)
    `CHK(wgo, 1'b1)
    `CHK(pat, PAT_ONES_9042)
    apb(1'b1, IDX_WCTL, 8'h18);
    pulse(1, 2);
    tick(1);
    `CHK(wgo, 1'b0)
    apb(1'b1, IDX_WCTL, 8'h18);
    apb(1'b1, IDX_MODE, 8'h08);
    tick(1);
    `CHK(wgo, 1'b0)
  endtask

  task automatic t_bcy();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_MODE, 8'h80 | dens[i]);
      apb(1'b1, IDX_WCTL, 8'h19);
      pulse(0, cells[i] - 1);
      apb(1'b0, IDX_WCTL, 8'h00);
      `CHK(rd[0], 1'b0)
      pulse(0, 1);
      apb(1'b0, IDX_WCTL, 8'h00);
      `CHK(rd[0], 1'b1)
    end
  endtask

  task automatic t_read();
    apb(1'b1, IDX_MODE, 8'h89);
    bfull <= 1'b1;
    apb(1'b0, IDX_WCTL, 8'h00);
    `CHK(rd[1], 1'b0)
    apb(1'b1, IDX_MODE, 8'h90);
    apb(1'b0, IDX_WCTL, 8'h00);
    `CHK(rd[1], 1'b1)
    apb(1'b1, IDX_RCTL, 8'h80);
    xcond <= 1'b1;
    tick(1);
    `CHK(xreq, 1'b1)
    `CHK(rgo, 1'b1)
    apb(1'b1, IDX_RCTL, 8'h98);
    tick(1);
    `CHK(xreq, 1'b0)
    `CHK(cinh, 1'b1)
    apb(1'b1, IDX_RCTL, 8'hA0);
    tick(1);
    `CHK(vfo, VFO_WCLK)
    pulse(2, 1);
    tick(0);
    `CHK(vfo, VFO_RESYNC)
    pulse(3, 1);
    tick(0);
    `CHK(vfo, VFO_DATA)
    apb(1'b1, IDX_RCTL, 8'hC0);
    tick(1);
    `CHK(vfo, VFO_DISCHARGE)
    pulse(4, 1);
    pulse(5, 1);
    apb(1'b0, IDX_STATUS, 8'h00);
    `CHK(rd[2], 1'b1)
    `CHK(rd[1], 1'b1)
    apb(1'b1, IDX_RCTL, 8'h80);
    apb(1'b0, IDX_STATUS, 8'h00);
    `CHK(rd[2], 1'b0)
    `CHK(rd[1], 1'b0)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tach();
    t_hardware_clear();
    t_mask();
    t_pat();
    t_fmt();
    t_bcy();
    t_read();
    print_verdict();
  end

  // the tach scenario alone needs about 46000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule

bind trwc_regs trwc_checker chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
  .i_format_step(i_format_step), .o_write_go(o_write_go), .o_format_count(o_format_count),
  .i_time_sense(i_time_sense), .i_peak_pulse(i_peak_pulse), .o_vfo_state(o_vfo_state)
);
